// ===== logic/qec_consts.svh
`ifndef QEC_CONSTS_SVH
`define QEC_CONSTS_SVH
// Width of each position counter.
`define QEC_CNT_W 32
// Number of counter channels.
`define QEC_NCH 2
// Width of the decoding select setting.
`define QEC_SEL_W 2
// Default decoding select: simple decoding on both channels.
`define QEC_SEL_RST 2'h0
// Input line numbers (zero based) carrying phase A of each channel.
`define QEC_CH0_A 3'h2
`define QEC_CH1_A 3'h4
// Number of digital input lines.
`define QEC_NLINE 8
// Reset value of a counter.
`define QEC_CNT_RST 32'h0000_0000
`endif

// ===== logic/qec_pkg.sv
package qec_pkg;
  // Signed position count of one channel.
  typedef logic signed [31:0] qec_count_t;
  // Decoding mode of one channel.
  typedef enum logic {
    QEC_SIMPLE = 1'b0,
    QEC_ENHANCED = 1'b1
  } qec_mode_t;
  // Owner of a shared input line.
  typedef enum logic [1:0] {
    QEC_OWN_NONE = 2'b00,
    QEC_OWN_COUNT = 2'b01,
    QEC_OWN_PULSE = 2'b10
  } qec_owner_t;
endpackage

// ===== logic/qec_channel.sv
`timescale 1ns/10ps
`include "qec_consts.svh"
// One decoder and counter channel working on already synchronised phases.
module qec_channel
  import qec_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic enable,
  input wire qec_pkg::qec_mode_t mode,
  input wire logic phase_a,
  input wire logic phase_b,
  input wire logic load,
  input wire qec_pkg::qec_count_t load_value,
  input wire logic target_load,
  input wire qec_pkg::qec_count_t target_value,
  output qec_pkg::qec_count_t count,
  output logic target_event
);
  // Previous sampled phase levels for edge detection.
  logic a_prev_reg, a_prev_next;
  logic b_prev_reg, b_prev_next;
  // Count, target and event flop.
  qec_count_t count_reg, count_next;
  qec_count_t target_reg, target_next;
  logic event_reg, event_next;
  // Last quadrature state in enhanced mode; repeated states add nothing.
  logic [1:0] last_q_reg, last_q_next;
  logic inc, dec;
  logic [1:0] q_now;

  // Decode edges and compute the next count and event state.
  always_comb begin
    a_prev_next = phase_a;
    b_prev_next = phase_b;
    count_next = count_reg;
    target_next = target_reg;
    last_q_next = last_q_reg;
    inc = 1'b0;
    dec = 1'b0;
    q_now = {phase_a, phase_b};
    if (mode == QEC_SIMPLE) begin
      // A rise while B is low counts up; a B rise while A is low counts down.
      // A single phase alone therefore counts in one direction.
      inc = phase_a && !a_prev_reg && !phase_b;
      dec = phase_b && !b_prev_reg && !phase_a;
      last_q_next = q_now;
    end else begin
      // The phases walk 00, 10, 11, 01 forward and the reverse way back.
      // A step up is made only when a forward cycle closes (01 to 00) and a step down
      // only when a backward one opens (00 to 01), so jitter about any one edge can
      // only swing the count by one and back, never pile up repeated counts.
      // The price is that a count lands at the end of a forward cycle, not its start.
      if (q_now != last_q_reg) begin
        last_q_next = q_now;
        if (q_now == 2'b00 && last_q_reg == 2'b01) begin
          inc = 1'b1;
        end else if (q_now == 2'b01 && last_q_reg == 2'b00) begin
          dec = 1'b1;
        end
      end
    end
    if (!enable) begin
      inc = 1'b0;
      dec = 1'b0;
    end
    // Each valid edge moves the count by exactly one.
    if (inc) begin
      count_next = count_reg + 32'sh0000_0001;
    end else if (dec) begin
      count_next = count_reg - 32'sh0000_0001;
    end
    // Software write of the count wins over a coincident edge.
    if (load) begin
      count_next = load_value;
    end
    // Software may arm a new target for the next event.
    if (target_load) begin
      target_next = target_value;
    end
    // One-cycle event when a counting step lands on the target.
    event_next = enable && (inc || dec) && (count_next == target_reg) && !load;
  end

  // Register the channel state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
      count_reg <= `QEC_CNT_RST;
      target_reg <= `QEC_CNT_RST;
      event_reg <= 1'b0;
      last_q_reg <= 2'h0;
    end else if (ce) begin
      a_prev_reg <= a_prev_next;
      b_prev_reg <= b_prev_next;
      count_reg <= count_next;
      target_reg <= target_next;
      event_reg <= event_next;
      last_q_reg <= last_q_next;
    end
  end

  assign count = count_reg;
  assign target_event = event_reg;
endmodule

// ===== logic/qec_top.sv
`timescale 1ns/10ps
`include "qec_consts.svh"
// Contract
// - Two channels on lines three-four, five-six.
// - A leading B increments once per pulse.
// - A lagging B decrements once per pulse.
// - Simple mode: A pulses, B low, increment.
// - Simple mode: B pulses, A low, decrement.
// - Simple mode allows single-phase counting.
// - Count reaching target raises event; reloadable.
// - Enhanced mode suppresses edge jitter counts.
// - Two-bit select: 0 simple, 1/2/3 enhanced; here bit 0 sets channel one's mode and bit 1 channel two's.
// - Counters are 32-bit signed.
// - Shared line: last configured function owns.
module qec_top
  import qec_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] in_lines,
  input wire logic [1:0] counter_define_command,
  input wire logic [1:0] counter_disable_command,
  input wire logic [1:0] pulse_measure_enable_command,
  input wire logic system_setting_command,
  input wire logic [1:0] system_setting_value,
  input wire logic [1:0] count_write,
  input wire qec_pkg::qec_count_t count_write_value,
  input wire logic [1:0] target_write,
  input wire qec_pkg::qec_count_t target_write_value,
  output qec_pkg::qec_count_t counter_value_0,
  output qec_pkg::qec_count_t counter_value_1,
  output logic [1:0] target_event_handler,
  output logic [1:0] counter_active,
  output logic [1:0] pulse_measure_active,
  output logic [7:0] ordinary_inputs
);
  // Two-flop synchronisers for the pins; only stage two is read.
  logic [7:0] sync1_reg, sync2_reg;
  // Decoding select, per-channel mode, and line ownership.
  logic [1:0] sel_reg, sel_next;
  qec_owner_t own_reg [2];
  qec_owner_t own_next [2];
  qec_count_t cnt [2];
  logic [1:0] evt;
  logic [1:0] act_reg, act_next;
  logic [1:0] pm_reg, pm_next;
  logic [7:0] ord_reg, ord_next;

  // Synchronise every input line before any decoding.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else if (ce) begin
      sync1_reg <= in_lines;
      sync2_reg <= sync1_reg;
    end
  end

  // Mode select and ownership; the most recent command takes the line.
  always_comb begin
    sel_next = sel_reg;
    if (system_setting_command) begin
      sel_next = system_setting_value;
    end
    for (int i = 0; i < `QEC_NCH; i++) begin
      own_next[i] = own_reg[i];
      if (counter_define_command[i]) begin
        own_next[i] = QEC_OWN_COUNT;
      end else if (pulse_measure_enable_command[i]) begin
        own_next[i] = QEC_OWN_PULSE;
      end else if (counter_disable_command[i] && own_reg[i] == QEC_OWN_COUNT) begin
        own_next[i] = QEC_OWN_NONE;
      end
      act_next[i] = (own_next[i] == QEC_OWN_COUNT);
      pm_next[i] = (own_next[i] == QEC_OWN_PULSE);
    end
    // Lines not held by a counter read back as plain inputs.
    ord_next = sync2_reg;
    if (act_next[0]) begin
      ord_next[3:2] = 2'h0;
    end
    if (act_next[1]) begin
      ord_next[5:4] = 2'h0;
    end
  end

  // Register mode, ownership and outputs.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_reg <= `QEC_SEL_RST;
      own_reg[0] <= QEC_OWN_NONE;
      own_reg[1] <= QEC_OWN_NONE;
      act_reg <= 2'h0;
      pm_reg <= 2'h0;
      ord_reg <= 8'h00;
    end else if (ce) begin
      sel_reg <= sel_next;
      own_reg <= own_next;
      act_reg <= act_next;
      pm_reg <= pm_next;
      ord_reg <= ord_next;
    end
  end

  // One channel per phase pair; channel one on lines 3-4, two on 5-6.
  for (genvar g = 0; g < `QEC_NCH; g++) begin : g_ch
    qec_channel u_ch (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .enable(act_reg[g]),
      .mode(qec_mode_t'(sel_reg[g])),
      .phase_a(sync2_reg[2 + 2 * g]),
      .phase_b(sync2_reg[3 + 2 * g]),
      .load(count_write[g]),
      .load_value(count_write_value),
      .target_load(target_write[g]),
      .target_value(target_write_value),
      .count(cnt[g]),
      .target_event(evt[g])
    );
  end

  // Counts and events come straight from the channel flops.
  assign counter_value_0 = cnt[0];
  assign counter_value_1 = cnt[1];
  assign target_event_handler = evt;
  assign counter_active = act_reg;
  assign pulse_measure_active = pm_reg;
  assign ordinary_inputs = ord_reg;
endmodule

// ===== verif/qec_monitor.sv
`timescale 1ns/10ps
// Watches ownership, stepping and event timing at the counter ports.
module qec_monitor
  import qec_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [1:0] counter_define_command,
  input wire logic [1:0] counter_disable_command,
  input wire logic [1:0] pulse_measure_enable_command,
  input wire logic [1:0] count_write,
  input wire qec_pkg::qec_count_t counter_value_0,
  input wire qec_pkg::qec_count_t counter_value_1,
  input wire logic [1:0] target_event_handler,
  input wire logic [1:0] counter_active,
  input wire logic [1:0] pulse_measure_active
);
  // All checks live in the one clock domain.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Without a write a count moves by one step at most, wrapping included.
  AST_STEP0: assert property (
    !count_write[0] |=> counter_value_0 - $past(counter_value_0) inside {-1, 0, 1})
    else $error("channel one count jumped");
  AST_STEP1: assert property (
    !count_write[1] |=> counter_value_1 - $past(counter_value_1) inside {-1, 0, 1})
    else $error("channel two count jumped");
  // Define wins over pulse measurement on a shared line.
  AST_DEF: assert property (
    ce && counter_define_command[0] |=> counter_active[0])
    else $error("define did not claim the lines");
  AST_PM: assert property (
    ce && pulse_measure_enable_command[0] && !counter_define_command[0]
    |=> pulse_measure_active[0] && !counter_active[0])
    else $error("pulse measurement did not take the line");
  AST_EXCL: assert property (
    !(counter_active[0] && pulse_measure_active[0]))
    else $error("line owned twice");
  AST_OFF: assert property (
    ce && counter_disable_command[0] && !counter_define_command[0] |=> !counter_active[0])
    else $error("disable ignored");
  // An idle channel keeps its count until software writes it.
  AST_HOLD: assert property (
    !counter_active[0] && !count_write[0] |=> $stable(counter_value_0))
    else $error("idle channel counted");
  AST_EVT1: assert property (
    target_event_handler[0] |=> !target_event_handler[0])
    else $error("event longer than one cycle");
  AST_EVTCNT: assert property (
    target_event_handler[0] |-> counter_value_0 != $past(counter_value_0))
    else $error("event without a count step");
endmodule

// ===== verif/qec_encoder_model.sv
`timescale 1ns/10ps
// Encoder model: quadrature or single-phase trains, changed at falling edges.
module qec_encoder_model #(
  parameter int QUARTER = 500
) (
  input wire logic clk,
  output logic phase_a,
  output logic phase_b
);
  // Both phases rest low between trains.
  initial {phase_a, phase_b} = 2'h0;
  // A quarter period of 500 cycles keeps the quadrature pulse rate at 10KHz, 20KHz for single-phase trains.
  task automatic step(input logic a, input logic b);
    repeat (QUARTER) @(negedge clk);
    {phase_a, phase_b} = {a, b};
  endtask
  // Reverse makes B lead; single moves only the leading phase.
  task automatic run(input int n, input bit rev, input bit single);
    for (int i = 0; i < n; i++) begin
      step(!rev, rev);
      if (!single) begin
        step(1'b1, 1'b1);
        step(rev, !rev);
      end
      step(1'b0, 1'b0);
    end
  endtask
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/10ps
// Self-checking bench for both encoder counter channels.
module tb_top;
  import qec_pkg::*;
  logic clk = 1'h0, rst = 1'h1, ce = 1'h1, sys_cmd = 1'h0;
  logic [1:0] def_cmd = 2'h0, off_cmd = 2'h0, pm_cmd = 2'h0, sys_val = 2'h0, cw = 2'h0, tw = 2'h0;
  qec_count_t cwv = 32'h0, twv = 32'h0, v0, v1;
  logic [1:0] evt, act, pma;
  logic [7:0] oin;
  logic a0, b0, a1, b1;
  int n_fail = 0, comparisons = 0, n_evt = 0, cyc = 0;
  initial forever #25 clk = ~clk;
  qec_top qec_top_inst (.clk(clk), .rst(rst), .ce(ce), .in_lines({2'h0, b1, a1, b0, a0, 2'h0}),
    .counter_define_command(def_cmd), .counter_disable_command(off_cmd),
    .pulse_measure_enable_command(pm_cmd), .system_setting_command(sys_cmd),
    .system_setting_value(sys_val), .count_write(cw), .count_write_value(cwv),
    .target_write(tw), .target_write_value(twv), .counter_value_0(v0), .counter_value_1(v1),
    .target_event_handler(evt), .counter_active(act), .pulse_measure_active(pma),
    .ordinary_inputs(oin));
  qec_encoder_model enc0 (.clk(clk), .phase_a(a0), .phase_b(b0));
  qec_encoder_model enc1 (.clk(clk), .phase_a(a1), .phase_b(b1));
  // Channel one's events are counted here, the cut-off for a hang also.
  always @(posedge clk) begin
    if (evt[0] === 1'h1) n_evt <= n_evt + 1;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // A one-cycle strobe; a second edge passes before the next call.
  task automatic pulse(ref logic [1:0] s, input logic [1:0] v);
    @(negedge clk) s = v;
    @(negedge clk) s = 2'h0;
  endtask
  // The sync and edge pipeline needs three cycles, so five is ample.
  task automatic settle();
    repeat (5) @(negedge clk);
  endtask
  task automatic t_own();
    pulse(pm_cmd, 2'h1);
    settle();
    chk("pm owns", 32'h1, {30'h0, pma} & 32'h1);
    pulse(def_cmd, 2'h3);
    settle();
    chk("counting owns", 32'h3, {28'h0, pma, act});
  endtask
  // Both channels at once, one forward and one backward.
  task automatic t_quad();
    fork
      enc0.run(3, 1'b0, 1'b0);
      enc1.run(3, 1'b1, 1'b0);
    join
    settle();
    chk("ch1 lead", 32'h3, v0);
    chk("ch2 lag", 32'hFFFFFFFD, v1);
  endtask
  task automatic t_single();
    enc0.run(2, 1'b0, 1'b1);
    settle();
    chk("A only", 32'h5, v0);
    enc0.run(2, 1'b1, 1'b1);
    settle();
    chk("B only", 32'h3, v0);
  endtask
  // One event on 5, then a new target of 4 met on the way back.
  task automatic t_target();
    twv = 32'h5;
    pulse(tw, 2'h1);
    enc0.run(3, 1'b0, 1'b0);
    settle();
    chk("first event", 32'h1, n_evt);
    twv = 32'h4;
    pulse(tw, 2'h1);
    enc0.run(2, 1'b1, 1'b0);
    settle();
    chk("second event", 32'h2, n_evt);
  endtask
  // A written minus one steps to zero across the wrap.
  task automatic t_wrap();
    cwv = 32'hFFFFFFFF;
    pulse(cw, 2'h2);
    enc1.run(1, 1'b0, 1'b0);
    settle();
    chk("wrap", 32'h0, v1);
  endtask
  // Enhanced decoding still counts clean steps; a disabled channel is deaf.
  task automatic t_enh();
    sys_val = 2'h3;
    @(negedge clk) sys_cmd = 1'h1;
    @(negedge clk) sys_cmd = 1'h0;
    cwv = 32'h0;
    pulse(cw, 2'h1);
    enc0.run(2, 1'b0, 1'b0);
    settle();
    chk("enhanced", 32'h2, v0);
    // Phase A dithers about its edge twice; the count must not creep.
    enc0.step(1'b1, 1'b0);
    enc0.step(1'b0, 1'b0);
    enc0.step(1'b1, 1'b0);
    enc0.step(1'b0, 1'b0);
    settle();
    chk("jitter", 32'h2, v0);
    pulse(off_cmd, 2'h1);
    enc0.run(1, 1'b0, 1'b0);
    settle();
    chk("disabled", 32'h2, v0);
    // A freed line reads back as a plain input; channel two's lines stay masked.
    enc0.step(1'b1, 1'b0);
    settle();
    chk("freed line", 32'h4, {24'h0, oin} & 32'h3C);
    enc0.step(1'b0, 1'b0);
  endtask
  task automatic test_done();
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'h0;
    chk("reset", 32'h0, v0);
    t_own();
    t_quad();
    t_single();
    t_target();
    t_wrap();
    t_enh();
    test_done();
  end
endmodule
bind qec_top qec_monitor qec_monitor_inst (.clk(clk), .rst(rst), .ce(ce),
  .counter_define_command(counter_define_command),
  .counter_disable_command(counter_disable_command),
  .pulse_measure_enable_command(pulse_measure_enable_command), .count_write(count_write),
  .counter_value_0(counter_value_0), .counter_value_1(counter_value_1),
  .target_event_handler(target_event_handler), .counter_active(counter_active),
  .pulse_measure_active(pulse_measure_active));
